// ---- core/tcs_defines.svh ----
// Timing counts and encodings for the tape unit command and status block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH
`define TCS_CLK_HZ          50000000
`define TCS_START_US        4500
`define TCS_STOP_US         4200
`define TCS_START_CYC       ((`TCS_START_US * (`TCS_CLK_HZ / 1000000)))
`define TCS_STOP_CYC        ((`TCS_STOP_US * (`TCS_CLK_HZ / 1000000)))
`define TCS_RATE_HI_HZ      50000
`define TCS_RATE_LO_HZ      18000
`define TCS_RATE_FAST_HZ    24000
`define TCS_RATE_EXT_HZ     72000
`define TCS_DIV_HI          (`TCS_CLK_HZ / `TCS_RATE_HI_HZ)
`define TCS_DIV_LO          (`TCS_CLK_HZ / `TCS_RATE_LO_HZ)
`define TCS_DIV_FAST        (`TCS_CLK_HZ / `TCS_RATE_FAST_HZ)
`define TCS_DIV_EXT         (`TCS_CLK_HZ / `TCS_RATE_EXT_HZ)
`define TCS_MIN_GROUP       7
`define TCS_DEN_LO          2'h0
`define TCS_DEN_HI          2'h1
`define TCS_DEN_EXT         2'h2
`endif

// ---- core/tcs_pkg.sv ----
// Types for the tape unit command and status block.
// Used by the single design module; holds no constants.
package tcs_pkg;
   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_ERASE, OP_BACKSPACE, OP_REWIND
   } tcs_order_t;

   typedef struct packed {
      tcs_order_t          order;
      logic                backward;
      logic                binary_mode;
   } tcs_cmd_t;

   typedef struct packed {
      logic       valid;
      logic [5:0] data;
   } tcs_char_t;
endpackage

// ---- core/tcs_unit.sv ----
// Command acceptance, timing and panel logic of one tape transport.
// Assumes the controller addresses this unit alone while issuing, and that
// panel switches and mechanism sense lines are asynchronous pins.
//
// Behaviour
// [RULE1] Accept read, write, erase, backspace, rewind orders.
// [RULE2] Any six-bit character passes unrestricted.
// [RULE3] Each transfer uses code or binary mode.
// [RULE4] Write and erase only moving forward.
// [RULE5] Read forward or backward as ordered.
// [RULE6] Controller instructs only one unit at once.
// [RULE7] Two switch-selected densities, 555.5 or 200.
// [RULE8] Character clock 50k high, 18k low, 24k fast.
// [RULE9] A character group holds at least seven; shorter groups are still written or read and flagged on group_short.
// [RULE10] Start delay 4.5 ms before first character.
// [RULE11] Stop delay 4.2 ms before next instruction.
// [RULE12] Local removes host control, lights local lamp.
// [RULE13] Remote gives host control, lights remote lamp.
// [RULE14] Unload only in local status.
// [RULE15] Rewind to load point only in local.
// [RULE16] Load only in local status.
// [RULE17] Write permit only with write ring.
// [RULE18] Density lamps show low or high.
// [RULE19] Extended variant adds 800 at 72k.
// [RULE20] In local, not ready and ignore orders.
`timescale 1ns/100ps
`default_nettype none
`include "tcs_defines.svh"

module tcs_unit
#(
   parameter int START_CYC = `TCS_START_CYC,
   parameter int STOP_CYC  = `TCS_STOP_CYC,
   parameter bit FAST_VARIANT = 1'b0,
   parameter bit EXT_VARIANT  = 1'b0
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   // Controller order port
   input  wire logic             cmd_valid,
   output logic                  cmd_ready,
   input  wire tcs_pkg::tcs_cmd_t cmd,
   output logic                  cmd_reject,
   output logic                  unit_ready,
   output logic                  busy,
   // Character stream
   input  wire tcs_pkg::tcs_char_t wr_char,
   output logic                  wr_take,
   input  wire logic             wr_last,
   output tcs_pkg::tcs_char_t    rd_char,
   input  wire logic [5:0]       head_rd_data,
   output logic [5:0]            head_wr_data,
   output logic                  head_wr_en,
   output logic                  head_erase_en,
   output logic                  binary_mode,
   output logic                  group_short,
   // Mechanism
   output logic                  motion_fwd,
   output logic                  motion_rev,
   output logic                  mech_load,
   output logic                  mech_unload,
   input  wire logic             at_load_point_pin,
   input  wire logic             end_of_tape_pin,
   input  wire logic             unload_done_pin,
   input  wire logic             load_done_pin,
   input  wire logic             gap_pin,
   // Operator panel
   input  wire logic             sw_local_pin,
   input  wire logic             sw_remote_pin,
   input  wire logic             sw_high_pin,
   input  wire logic             sw_low_pin,
   input  wire logic             sw_800_pin,
   input  wire logic             sw_unload_pin,
   input  wire logic             sw_rewind_pin,
   input  wire logic             sw_load_pin,
   input  wire logic             ring_pin,
   output logic                  lamp_local,
   output logic                  lamp_remote,
   output logic                  lamp_low,
   output logic                  lamp_high,
   output logic                  lamp_800,
   output logic                  write_permit,
   output logic                  char_tick
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int NPIN = 14;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_m_q;
   logic [NPIN-1:0] pin_q;
   logic [NPIN-1:0] pin_prev_q;
   logic [NPIN-1:0] pin_rise;

   assign pin_raw = {sw_local_pin, sw_remote_pin, sw_high_pin, sw_low_pin, sw_800_pin,
                     sw_unload_pin, sw_rewind_pin, sw_load_pin, ring_pin,
                     at_load_point_pin, end_of_tape_pin, unload_done_pin,
                     load_done_pin, gap_pin};

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_m_q    <= '0;
         pin_q      <= '0;
         pin_prev_q <= '0;
      end
      else
      begin
         pin_m_q    <= pin_raw;
         pin_q      <= pin_m_q;
         pin_prev_q <= pin_q;
      end
   end

   assign pin_rise = pin_q & ~pin_prev_q;

   logic p_local, p_remote, p_high, p_low, p_800, p_unload, p_rewind, p_load;
   logic s_ring, s_bot, s_eot, s_unl_done, s_load_done, s_gap;
   assign {p_local, p_remote, p_high, p_low, p_800, p_unload, p_rewind, p_load} =
          pin_rise[13:6];
   assign {s_ring, s_bot, s_eot, s_unl_done, s_load_done, s_gap} = pin_q[5:0];

   // ------------------------------------------------------------
   // Local / remote status and density selection
   // ------------------------------------------------------------
   logic       local_q;
   logic [1:0] density_q;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         local_q <= 1'b1;
      else if (p_local)
         local_q <= 1'b1;                                   // see [RULE12]
      else if (p_remote)
         local_q <= 1'b0;                                   // see [RULE13]
   end

   // Density may only change while the transport is idle, so a group is
   // never written at two densities.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         density_q <= `TCS_DEN_LO;
      else if (!busy)
      begin
         if (FAST_VARIANT)
            density_q <= `TCS_DEN_LO;                       // see [RULE8]
         else if (p_800 && EXT_VARIANT)
            density_q <= `TCS_DEN_EXT;                      // see [RULE19]
         else if (p_high)
            density_q <= `TCS_DEN_HI;                       // see [RULE7]
         else if (p_low)
            density_q <= `TCS_DEN_LO;                       // see [RULE7]
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         lamp_local   <= 1'b1;
         lamp_remote  <= 1'b0;
         lamp_low     <= 1'b1;
         lamp_high    <= 1'b0;
         lamp_800     <= 1'b0;
         write_permit <= 1'b0;
      end
      else
      begin
         lamp_local   <= local_q;                           // see [RULE12]
         lamp_remote  <= !local_q;                          // see [RULE13]
         lamp_low     <= (density_q == `TCS_DEN_LO);        // see [RULE18]
         lamp_high    <= (density_q == `TCS_DEN_HI);        // see [RULE18]
         lamp_800     <= (density_q == `TCS_DEN_EXT);       // see [RULE19]
         write_permit <= s_ring;                            // see [RULE17]
      end
   end

   // ------------------------------------------------------------
   // Character clock
   // ------------------------------------------------------------
   logic [11:0] div_q;
   logic [11:0] div_top;

   always_comb
   begin
      unique case (density_q)
         `TCS_DEN_HI:  div_top = 12'(`TCS_DIV_HI - 1);
         `TCS_DEN_EXT: div_top = 12'(`TCS_DIV_EXT - 1);
         default:      div_top = FAST_VARIANT ? 12'(`TCS_DIV_FAST - 1)
                                              : 12'(`TCS_DIV_LO - 1);
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         div_q <= 12'h000;
      else if (div_q >= div_top)
         div_q <= 12'h000;
      else
         div_q <= div_q + 12'h001;
   end

   assign char_tick = (div_q == 12'h000);                   // see [RULE8]

   // ------------------------------------------------------------
   // Order sequencer
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_XFER, ST_STOP, ST_REWIND, ST_LOAD, ST_UNLOAD
   } tcs_state_t;

   tcs_state_t         state_q;
   tcs_pkg::tcs_cmd_t  cur_q;
   logic [17:0]        tmr_q;
   logic [15:0]        count_q;
   logic               cmd_ok;

   // Orders are not taken in local status, nor before the local lamp is out.
   assign unit_ready = !local_q && !lamp_local && (state_q == ST_IDLE); // see [RULE20]
   assign cmd_ready  = unit_ready;
   assign busy       = (state_q != ST_IDLE);

   // Writing needs the ring; write and erase cannot run backward.
   function automatic logic order_legal(tcs_pkg::tcs_cmd_t c, logic ring);
      logic ok;
      ok = 1'b1;
      if ((c.order == tcs_pkg::OP_WRITE || c.order == tcs_pkg::OP_ERASE) && c.backward)
         ok = 1'b0;                                         // see [RULE4]
      if (c.order == tcs_pkg::OP_WRITE && !ring)
         ok = 1'b0;                                         // see [RULE17]
      if (c.order == tcs_pkg::OP_BACKSPACE && !c.backward)
         ok = 1'b1;
      return ok;
   endfunction

   assign cmd_ok = order_legal(cmd, s_ring);

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q    <= ST_IDLE;
         cur_q      <= '0;
         tmr_q      <= 18'h00000;
         cmd_reject <= 1'b0;
      end
      else
      begin
         cmd_reject <= 1'b0;
         unique case (state_q)
            ST_IDLE:
            begin
               if (cmd_valid && unit_ready)                 // see [RULE1]
               begin
                  if (!cmd_ok)
                     cmd_reject <= 1'b1;
                  else if (cmd.order == tcs_pkg::OP_REWIND)
                     state_q <= ST_REWIND;
                  else
                  begin
                     cur_q   <= cmd;
                     tmr_q   <= 18'(START_CYC - 1);
                     state_q <= ST_START;
                  end
               end
               else if (local_q && p_rewind)
                  state_q <= ST_REWIND;                     // see [RULE15]
               else if (local_q && p_load)
                  state_q <= ST_LOAD;                       // see [RULE16]
               else if (local_q && p_unload)
                  state_q <= ST_UNLOAD;                     // see [RULE14]
            end
            ST_START:
            begin
               if (tmr_q == 18'h00000)
                  state_q <= ST_XFER;                       // see [RULE10]
               else
                  tmr_q <= tmr_q - 18'h00001;
            end
            ST_XFER:
            begin
               if (s_eot || (cur_q.order == tcs_pkg::OP_WRITE ? (wr_take && wr_last)
                                                               : s_gap))
               begin
                  tmr_q   <= 18'(STOP_CYC - 1);
                  state_q <= ST_STOP;
               end
            end
            ST_STOP:
            begin
               if (tmr_q == 18'h00000)
                  state_q <= ST_IDLE;                       // see [RULE11]
               else
                  tmr_q <= tmr_q - 18'h00001;
            end
            ST_REWIND:
               if (s_bot)
                  state_q <= ST_IDLE;
            ST_LOAD:
               if (s_load_done)
                  state_q <= ST_IDLE;
            ST_UNLOAD:
               if (s_unl_done)
                  state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Motion and head drive
   // ------------------------------------------------------------
   logic xfer;
   assign xfer = (state_q == ST_XFER);
   assign wr_take = xfer && cur_q.order == tcs_pkg::OP_WRITE && char_tick && wr_char.valid;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         motion_fwd    <= 1'b0;
         motion_rev    <= 1'b0;
         mech_load     <= 1'b0;
         mech_unload   <= 1'b0;
         head_wr_en    <= 1'b0;
         head_erase_en <= 1'b0;
         binary_mode   <= 1'b0;
      end
      else
      begin
         motion_fwd    <= (state_q == ST_START || xfer) && !cur_q.backward; // see [RULE5]
         motion_rev    <= ((state_q == ST_START || xfer) && cur_q.backward)
                          || state_q == ST_REWIND || state_q == ST_UNLOAD;
         mech_load     <= (state_q == ST_LOAD);
         mech_unload   <= (state_q == ST_UNLOAD);
         head_wr_en    <= xfer && cur_q.order == tcs_pkg::OP_WRITE
                          && !cur_q.backward && s_ring;     // see [RULE4]
         head_erase_en <= xfer && cur_q.order == tcs_pkg::OP_ERASE
                          && !cur_q.backward;               // see [RULE4]
         binary_mode   <= cur_q.binary_mode;                // see [RULE3]
      end
   end

   // ------------------------------------------------------------
   // Character path and group length check
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         head_wr_data <= 6'h00;
         rd_char      <= '0;
         count_q      <= 16'h0000;
         group_short  <= 1'b0;
      end
      else
      begin
         rd_char.valid <= 1'b0;
         if (state_q == ST_START)
            count_q <= 16'h0000;
         if (wr_take)
         begin
            head_wr_data <= wr_char.data;                   // see [RULE2]
            count_q      <= count_q + 16'h0001;
         end
         if (xfer && cur_q.order == tcs_pkg::OP_READ && char_tick && !s_gap)
         begin
            rd_char.valid <= 1'b1;
            rd_char.data  <= head_rd_data;                  // see [RULE2]
            count_q       <= count_q + 16'h0001;
         end
         // Flag groups under the minimum length when the group closes.
         if (state_q == ST_STOP && tmr_q == 18'(STOP_CYC - 1))
            group_short <= (cur_q.order == tcs_pkg::OP_WRITE || cur_q.order == tcs_pkg::OP_READ)
                           && count_q < 16'(`TCS_MIN_GROUP); // see [RULE9]
      end
   end

endmodule

`default_nettype wire

// ---- verification/tcs_ctl_model.sv ----
// Controller side model: offers one order at a time to the tape unit.
// Assumes the bench clock; drives only on its falling edge.
`timescale 1ns/100ps
`default_nettype none
module tcs_ctl_model
(
   // Clock
   input  wire logic         clk_sys,
   // Order port
   input  wire logic         cmd_ready,
   output logic              cmd_valid,
   output tcs_pkg::tcs_cmd_t cmd
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // One order stands until ready is seen or lim clock edges pass, which also covers the stop time.
   task automatic offer(input tcs_pkg::tcs_cmd_t c, input int lim, output bit taken);
      int n;
      n = 0;
      taken = 1'b0;
      @(negedge clk_sys);
      cmd = c;
      cmd_valid = 1'b1;
      while (!taken && n < lim)
      begin
         @(posedge clk_sys);
         taken = (cmd_ready === 1'b1);
         n++;
      end
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cmd = ~c;
   endtask
endmodule
`default_nettype wire

// ---- verification/tcs_unit_checker.sv ----
// Checker for tcs_unit orders, head use and panel lamps.
// Bound to every tcs_unit; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module tcs_unit_checker
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   // Orders
   input  wire logic              cmd_valid,
   input  wire logic              cmd_ready,
   input  wire tcs_pkg::tcs_cmd_t cmd,
   input  wire logic              cmd_reject,
   input  wire logic              unit_ready,
   input  wire logic              busy,
   // Head and panel
   input  wire logic              head_wr_en,
   input  wire logic              head_erase_en,
   input  wire logic              motion_rev,
   input  wire logic              write_permit,
   input  wire logic              lamp_local,
   input  wire logic              lamp_remote,
   input  wire logic              lamp_low,
   input  wire logic              lamp_high
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_take;
      cmd_valid && cmd_ready;
   endsequence
   sequence s_bad_dir;
      s_take ##0 (cmd.backward && cmd.order inside {tcs_pkg::OP_WRITE, tcs_pkg::OP_ERASE});
   endsequence

   a_reject_reverse: assert property (s_bad_dir |=> cmd_reject)
      else $error("reverse write or erase not refused");
   a_head_fwd_only: assert property ((head_wr_en || head_erase_en) |-> !motion_rev)
      else $error("head active while moving backward");
   a_ring_to_write: assert property (head_wr_en |-> write_permit)
      else $error("write without permit");
   a_take_answer: assert property (s_take |=> (busy != cmd_reject))
      else $error("order neither started nor refused");
   a_start_quiet: assert property ($rose(busy) |-> !(head_wr_en || head_erase_en) [*8])
      else $error("head active inside start time");
   a_ready_idle: assert property (cmd_ready |-> (unit_ready && !busy))
      else $error("ready while busy");
   a_local_refuse: assert property (lamp_local |-> !unit_ready)
      else $error("ready in local status");
   a_lamp_pair: assert property (lamp_local != lamp_remote)
      else $error("local and remote lamps agree");
   a_density_lamp: assert property (lamp_low != lamp_high)
      else $error("density lamps agree");
endmodule

bind tcs_unit tcs_unit_checker u_chk (.*);
`default_nettype wire

// ---- verification/tcs_unit_test.sv ----
// Self-checking bench for tcs_unit with a controller model.
// Runs the unit with short start and stop counts.
`timescale 1ns/100ps
`default_nettype none
module tcs_unit_test;
   localparam int ST = 20;
   localparam int SP = 15;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic cmd_valid, cmd_ready, cmd_reject, unit_ready, busy, wr_take, wr_last;
   logic head_wr_en, head_erase_en, binary_mode, group_short, motion_fwd, motion_rev;
   logic mech_load, mech_unload, at_load_point_pin, end_of_tape_pin, unload_done_pin;
   logic load_done_pin, gap_pin, sw_local_pin, sw_remote_pin, sw_high_pin, sw_low_pin;
   logic sw_800_pin, sw_unload_pin, sw_rewind_pin, sw_load_pin, ring_pin, lamp_local;
   logic lamp_remote, lamp_low, lamp_high, lamp_800, write_permit, char_tick;
   logic [5:0]         head_rd_data, head_wr_data;
   tcs_pkg::tcs_cmd_t  cmd;
   tcs_pkg::tcs_char_t wr_char, rd_char;
   logic [31:0]        seed = 32'h8c3b;
   int                 errors = 0;
   int                 check_count = 0;
   bit                 tk;
   logic [5:0]         q[$];

   always #10 clk_sys = ~clk_sys;
   tcs_unit #(.START_CYC(ST), .STOP_CYC(SP)) dut (.*);
   tcs_ctl_model ctl (.clk_sys, .cmd_ready, .cmd_valid, .cmd);

   function automatic logic [5:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[5:0];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic p);
      @(negedge clk_sys);
      p = 1'b1;
      repeat (5) @(negedge clk_sys);
      p = 1'b0;
   endtask
   task automatic idle(input int lim);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < lim)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(busy, 1'b0);
   endtask
   task automatic order(input logic [2:0] o, input logic bk, input logic bin);
      tcs_pkg::tcs_cmd_t c;
      c.order = tcs_pkg::tcs_order_t'(o);
      c.backward = bk;
      c.binary_mode = bin;
      ctl.offer(c, 200, tk);
   endtask
   task automatic period(input int exp);
      int n;
      n = 0;
      @(posedge char_tick);
      @(negedge clk_sys);
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (char_tick !== 1'b1 && n < 5000);
      chk(n, exp);
   endtask
   task automatic wr_group(input int len);
      int i;
      int n;
      q = {};
      for (i = 0; i < len; i++)
         q.push_back(rnd());
      i = 0;
      n = 0;
      wr_char = {1'b1, q[0]};
      wr_last = (len == 1);
      order(3'h1, 1'b0, len[0]);
      while (i < len && n < 30000)
      begin
         @(posedge clk_sys);
         n++;
         if (wr_take === 1'b1)
         begin
            @(negedge clk_sys);
            chk(head_wr_data, q[i]);
            chk(binary_mode, len[0]);
            chk({motion_fwd, head_wr_en}, 2'h3);
            i++;
            wr_char = {i < len, q[i % len]};
            wr_last = (i == len - 1);
         end
      end
      chk(i, len);
      idle(ST + SP + 50);
      chk(group_short, len < 7);
      $display("write group of %0d done", len);
   endtask
   task automatic rd_group(input logic bk);
      int i;
      int n;
      logic [5:0] d;
      order(3'h0, bk, 1'b0);
      for (i = 0; i < 3; i++)
      begin
         d = rnd();
         head_rd_data = d;
         n = 0;
         while (rd_char.valid !== 1'b1 && n < 5000)
         begin
            @(negedge clk_sys);
            n++;
         end
         chk(rd_char.data, d);
         chk(motion_rev, bk);
         chk(binary_mode, 1'b0);
         @(negedge clk_sys);
      end
      if (bk)
         pulse(end_of_tape_pin);
      else
         pulse(gap_pin);
      idle(ST + SP + 50);
      $display("read direction %0d done", bk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      {wr_last, head_rd_data, at_load_point_pin, end_of_tape_pin, unload_done_pin} = '0;
      {load_done_pin, gap_pin, sw_local_pin, sw_remote_pin, sw_high_pin, sw_low_pin} = '0;
      {sw_800_pin, sw_unload_pin, sw_rewind_pin, sw_load_pin, ring_pin} = '0;
      wr_char = '0;
      repeat (8) @(negedge clk_sys);
      nrst = 1'b1;
      chk({lamp_local, lamp_remote, lamp_low, lamp_high}, 4'ha);
      order(3'h0, 1'b0, 1'b0);
      chk(tk, 1'b0);
      pulse(sw_remote_pin);
      chk({lamp_local, lamp_remote, unit_ready, write_permit}, 4'h6);
      order(3'h1, 1'b0, 1'b0);
      chk(cmd_reject, 1'b1);
      ring_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(write_permit, 1'b1);
      order(3'h2, 1'b1, 1'b0);
      chk(cmd_reject, 1'b1);
      $display("remote and refusal done");
      wr_group(7);
      wr_group(3);
      rd_group(1'b1);
      rd_group(1'b0);
      for (int o = 2; o < 5; o++)
      begin
         order(o[2:0], 1'b0, 1'b0);
         repeat (ST + 3) @(negedge clk_sys);
         chk(busy, 1'b1);
         chk(head_erase_en, o == 2);
         pulse(gap_pin);
         pulse(at_load_point_pin);
         idle(ST + SP + 50);
      end
      pulse(sw_high_pin);
      chk({lamp_low, lamp_high, lamp_800}, 3'h2);
      period(1000);
      pulse(sw_low_pin);
      period(2777);
      $display("orders and density done");
      pulse(sw_local_pin);
      chk({lamp_local, unit_ready}, 2'h2);
      order(3'h0, 1'b0, 1'b0);
      chk(tk, 1'b0);
      pulse(sw_rewind_pin);
      chk(motion_rev, 1'b1);
      pulse(at_load_point_pin);
      idle(50);
      pulse(sw_unload_pin);
      chk(mech_unload, 1'b1);
      pulse(unload_done_pin);
      idle(50);
      pulse(sw_load_pin);
      chk(mech_load, 1'b1);
      pulse(load_done_pin);
      idle(50);
      $display("local panel done");
      tally_and_finish();
   end

   initial
   begin
      repeat (90000) @(posedge clk_sys);
      errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
